// File: hdl/reload_timer_pkg.sv
// constants for the auto-reload timer control block: register addresses,
// control field positions, reset values and clock divider counts.
// assumes an 8-bit special function register port on the core clock.
package reload_timer_pkg;

  // ------------------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL_STATUS = 8'h91;
  localparam logic [7:0] ADDR_RELOAD_LOW     = 8'h92;
  localparam logic [7:0] ADDR_RELOAD_HIGH    = 8'h93;
  localparam logic [7:0] ADDR_COUNT_LOW      = 8'h94;
  localparam logic [7:0] ADDR_COUNT_HIGH     = 8'h95;

  // ------------------------------------------------------------------------
  // control_status_reg field positions
  // ------------------------------------------------------------------------
  localparam int BIT_HIGH_FLAG     = 7;
  localparam int BIT_LOW_FLAG      = 6;
  localparam int BIT_LOW_IRQ_EN    = 5;
  localparam int BIT_CAPTURE_EN    = 4;
  localparam int BIT_SPLIT         = 3;
  localparam int BIT_RUN           = 2;
  localparam int BIT_ALT_CLK_HI    = 1;
  localparam int BIT_ALT_CLK_LO    = 0;

  // ------------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------------
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [7:0] RESET_RELOAD  = 8'h00;
  localparam logic [7:0] RESET_COUNT   = 8'h00;

  // ------------------------------------------------------------------------
  // alternate clock encodings and divider counts
  // ------------------------------------------------------------------------
  localparam logic [1:0] ALT_CORE_DIV12 = 2'h0;
  localparam logic [1:0] ALT_EXT_DIV8   = 2'h1;
  localparam logic [1:0] ALT_RESERVED   = 2'h2;
  localparam logic [1:0] ALT_LFO_DIV8   = 2'h3;
  localparam int         CORE_DIVIDE    = 12;
  localparam int         PIN_DIVIDE     = 8;
  localparam logic [7:0] BYTE_ALL_ONES  = 8'hff;

endpackage

// File: hdl/auto_reload_timer_control.sv
// 16-bit auto-reload timer with split 8-bit mode, low-frequency oscillator
// capture, overflow flags and interrupt request.
// assumes the register port and enable inputs are on mclk; the external
// clock and oscillator pins are asynchronous and are synchronised here.
//
// How it works
// - high flag sets when the upper count byte overflows past ff.
// - in 16-bit mode high flag sets when full count wraps from ffff to the reload value.
// - a set high flag with timer interrupts enabled raises the interrupt request.
// - flags are cleared only by software writing zero, never by hardware.
// - low flag sets when lower byte wraps, in both modes.
// - low flag also requests interrupt when low-byte enable and interrupts are on.
// - capture enabled: oscillator falling edge copies the count into both reload registers.
// - capture mode with interrupts enabled interrupts on each oscillator falling edge.
// - split bit zero gives one 16-bit counter, one gives two 8-bit counters.
// - in 16-bit mode the counter runs only while run bit is one.
// - in split mode run bit gates only the upper byte; lower byte always runs.
// - alternate select 00 core/12, 01 external/8, 10 reserved, 11 oscillator/8.
// - external and oscillator divided sources are synchronised to the core clock.
// - in split mode alternate select serves both bytes, per-byte select may override.
// - low reload register is read/write, resets to zero.
// - high reload register is read/write, resets to zero.
// - 16-bit wrap loads the combined reload value into the counter.
// - in split mode each byte reloads from its own reload register on overflow.
// - per-byte clock select one uses core clock, zero uses the alternate source.
`timescale 1ns/1ps
`default_nettype none

module auto_reload_timer_control
  import reload_timer_pkg::*;
(
  input  wire  logic       mclk,
  input  wire  logic       reset_n,
  input  wire  logic [7:0] sfr_addr,
  input  wire  logic [7:0] sfr_wdata,
  input  wire  logic       sfr_wr_en,
  input  wire  logic       sfr_rd_en,
  input  wire  logic       timer_irq_enable,
  input  wire  logic       high_byte_clock_select,
  input  wire  logic       low_byte_clock_select,
  input  wire  logic       ext_clock_pin,
  input  wire  logic       low_freq_oscillator,
  output logic [7:0]       sfr_rdata_q,
  output logic             timer_irq_q,
  output logic             high_overflow_pulse_q,
  output logic             low_overflow_pulse_q
);

  // ------------------------------------------------------------------------
  // register state
  // ------------------------------------------------------------------------
  logic       high_overflow_flag_q;
  logic       low_overflow_flag_q;
  logic       low_byte_irq_enable_q;
  logic       lfo_capture_enable_q;
  logic       split_mode_select_q;
  logic       run_control_bit_q;
  logic [1:0] alt_clock_select_q;
  logic [7:0] reload_low_byte_q;
  logic [7:0] reload_high_byte_q;
  logic [7:0] count_low_byte_q;
  logic [7:0] count_high_byte_q;

  // ------------------------------------------------------------------------
  // pin synchronisers and dividers
  // ------------------------------------------------------------------------
  logic       ext_meta_q;
  logic       ext_sync_q;
  logic       ext_prev_q;
  logic       lfo_meta_q;
  logic       lfo_sync_q;
  logic       lfo_prev_q;
  logic [3:0] core_div_q;
  logic [2:0] ext_div_q;
  logic [2:0] lfo_div_q;

  // both pins pass two flops before any edge logic reads them
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
      lfo_meta_q <= 1'b0;
      lfo_sync_q <= 1'b0;
      lfo_prev_q <= 1'b0;
    end else begin
      ext_meta_q <= ext_clock_pin;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
      lfo_meta_q <= low_freq_oscillator;
      lfo_sync_q <= lfo_meta_q;
      lfo_prev_q <= lfo_sync_q;
    end
  end

  // edge detect and divider terminal counts
  wire ext_rise   = ext_sync_q & ~ext_prev_q;
  wire lfo_rise   = lfo_sync_q & ~lfo_prev_q;
  wire lfo_fall   = ~lfo_sync_q & lfo_prev_q;
  wire core_tick  = (core_div_q == 4'(CORE_DIVIDE - 1));
  wire ext_tick   = ext_rise & (ext_div_q == 3'(PIN_DIVIDE - 1));
  wire lfo_tick   = lfo_rise & (lfo_div_q == 3'(PIN_DIVIDE - 1));

  // free-running dividers; 3-bit pin dividers wrap naturally at eight
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      core_div_q <= 4'h0;
      ext_div_q  <= 3'h0;
      lfo_div_q  <= 3'h0;
    end else begin
      core_div_q <= core_tick ? 4'h0 : core_div_q + 4'h1;
      if (ext_rise) begin
        ext_div_q <= ext_div_q + 3'h1;
      end
      if (lfo_rise) begin
        lfo_div_q <= lfo_div_q + 3'h1;
      end
    end
  end

  // ------------------------------------------------------------------------
  // count clock selection
  // ------------------------------------------------------------------------
  logic alt_tick;

  // reserved encoding gives no ticks, so the timer stalls unless a per-byte select is one
  always_comb begin
    case (alt_clock_select_q)
      ALT_CORE_DIV12: alt_tick = core_tick;
      ALT_EXT_DIV8:   alt_tick = ext_tick;
      ALT_LFO_DIV8:   alt_tick = lfo_tick;
      default:        alt_tick = 1'b0;
    endcase
  end

  // per-byte select picks core clock over the shared alternate source
  wire tick_low  = low_byte_clock_select | alt_tick;
  wire tick_high = high_byte_clock_select | alt_tick;

  // ------------------------------------------------------------------------
  // counting, overflow and reload
  // ------------------------------------------------------------------------
  // the low byte clock drives the whole 16-bit counter
  wire step_low   = split_mode_select_q ? tick_low : (tick_low & run_control_bit_q);
  wire step_high  = split_mode_select_q ? (tick_high & run_control_bit_q) : 1'b0;
  wire low_wrap   = step_low & (count_low_byte_q == BYTE_ALL_ONES);
  wire wrap16     = ~split_mode_select_q & low_wrap & (count_high_byte_q == BYTE_ALL_ONES);
  wire split_hi_w = step_high & (count_high_byte_q == BYTE_ALL_ONES);
  wire high_wrap  = wrap16 | split_hi_w;
  wire carry16    = ~split_mode_select_q & low_wrap & ~wrap16;

  // capture sets the high flag so the interrupt follows the edge
  wire capture    = lfo_capture_enable_q & lfo_fall;

  // register write decode
  wire wr_ctrl    = sfr_wr_en & (sfr_addr == ADDR_CONTROL_STATUS);
  wire wr_rl_low  = sfr_wr_en & (sfr_addr == ADDR_RELOAD_LOW);
  wire wr_rl_high = sfr_wr_en & (sfr_addr == ADDR_RELOAD_HIGH);
  wire wr_cnt_low = sfr_wr_en & (sfr_addr == ADDR_COUNT_LOW);
  wire wr_cnt_hi  = sfr_wr_en & (sfr_addr == ADDR_COUNT_HIGH);

  // next count: software write wins over counting in the same cycle
  logic [7:0] count_low_d;
  logic [7:0] count_high_d;
  always_comb begin
    count_low_d  = count_low_byte_q;
    count_high_d = count_high_byte_q;
    if (wrap16) begin
      count_low_d  = reload_low_byte_q;
      count_high_d = reload_high_byte_q;
    end else begin
      if (low_wrap) begin
        count_low_d = split_mode_select_q ? reload_low_byte_q : 8'h00;
      end else if (step_low) begin
        count_low_d = count_low_byte_q + 8'h01;
      end
      if (split_hi_w) begin
        count_high_d = reload_high_byte_q;
      end else if (step_high | carry16) begin
        count_high_d = count_high_byte_q + 8'h01;
      end
    end
    if (wr_cnt_low) begin
      count_low_d = sfr_wdata;
    end
    if (wr_cnt_hi) begin
      count_high_d = sfr_wdata;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count_low_byte_q  <= RESET_COUNT;
      count_high_byte_q <= RESET_COUNT;
    end else begin
      count_low_byte_q  <= count_low_d;
      count_high_byte_q <= count_high_d;
    end
  end

  // ------------------------------------------------------------------------
  // reload registers
  // ------------------------------------------------------------------------
  // a capture beats a software write of the same cycle; losing a measurement
  // would corrupt the frequency reading silently
  wire [7:0] reload_low_d  = capture ? count_low_byte_q :
                             (wr_rl_low ? sfr_wdata : reload_low_byte_q);
  wire [7:0] reload_high_d = capture ? count_high_byte_q :
                             (wr_rl_high ? sfr_wdata : reload_high_byte_q);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reload_low_byte_q  <= RESET_RELOAD;
      reload_high_byte_q <= RESET_RELOAD;
    end else begin
      reload_low_byte_q  <= reload_low_d;
      reload_high_byte_q <= reload_high_d;
    end
  end

  // ------------------------------------------------------------------------
  // control and status register
  // ------------------------------------------------------------------------
  // hardware only sets the flags; a set in the write cycle wins over a clear
  wire high_flag_d = high_wrap | capture |
                     (wr_ctrl ? sfr_wdata[BIT_HIGH_FLAG] : high_overflow_flag_q);
  wire low_flag_d  = low_wrap |
                     (wr_ctrl ? sfr_wdata[BIT_LOW_FLAG] : low_overflow_flag_q);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      high_overflow_flag_q  <= RESET_CONTROL[BIT_HIGH_FLAG];
      low_overflow_flag_q   <= RESET_CONTROL[BIT_LOW_FLAG];
      low_byte_irq_enable_q <= RESET_CONTROL[BIT_LOW_IRQ_EN];
      lfo_capture_enable_q  <= RESET_CONTROL[BIT_CAPTURE_EN];
      split_mode_select_q   <= RESET_CONTROL[BIT_SPLIT];
      run_control_bit_q     <= RESET_CONTROL[BIT_RUN];
      alt_clock_select_q    <= RESET_CONTROL[BIT_ALT_CLK_HI:BIT_ALT_CLK_LO];
    end else begin
      high_overflow_flag_q <= high_flag_d;
      low_overflow_flag_q  <= low_flag_d;
      if (wr_ctrl) begin
        low_byte_irq_enable_q <= sfr_wdata[BIT_LOW_IRQ_EN];
        lfo_capture_enable_q  <= sfr_wdata[BIT_CAPTURE_EN];
        split_mode_select_q   <= sfr_wdata[BIT_SPLIT];
        run_control_bit_q     <= sfr_wdata[BIT_RUN];
        alt_clock_select_q    <= sfr_wdata[BIT_ALT_CLK_HI:BIT_ALT_CLK_LO];
      end
    end
  end

  // ------------------------------------------------------------------------
  // read port, interrupt and overflow outputs
  // ------------------------------------------------------------------------
  wire [7:0] control_status_reg = {high_overflow_flag_q, low_overflow_flag_q,
                                   low_byte_irq_enable_q, lfo_capture_enable_q,
                                   split_mode_select_q, run_control_bit_q,
                                   alt_clock_select_q};

  // unmapped addresses read as zero
  wire [7:0] read_mux =
    (sfr_addr == ADDR_CONTROL_STATUS) ? control_status_reg :
    (sfr_addr == ADDR_RELOAD_LOW)     ? reload_low_byte_q  :
    (sfr_addr == ADDR_RELOAD_HIGH)    ? reload_high_byte_q :
    (sfr_addr == ADDR_COUNT_LOW)      ? count_low_byte_q   :
    (sfr_addr == ADDR_COUNT_HIGH)     ? count_high_byte_q  : 8'h00;

  // request is a level from the flags, so it holds until software clears them
  wire irq_d = timer_irq_enable &
               (high_overflow_flag_q | (low_overflow_flag_q & low_byte_irq_enable_q));

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sfr_rdata_q           <= 8'h00;
      timer_irq_q           <= 1'b0;
      high_overflow_pulse_q <= 1'b0;
      low_overflow_pulse_q  <= 1'b0;
    end else begin
      if (sfr_rd_en) begin
        sfr_rdata_q <= read_mux;
      end
      timer_irq_q           <= irq_d;
      high_overflow_pulse_q <= high_wrap;
      low_overflow_pulse_q  <= low_wrap;
    end
  end

  // ------------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  wrap_reload_a: assert property (
    wrap16 && !wr_cnt_low && !wr_cnt_hi |=> high_overflow_flag_q &&
      {count_high_byte_q, count_low_byte_q} == $past({reload_high_byte_q, reload_low_byte_q}))
    else $error("16-bit wrap did not reload and flag");

  low_flag_set_a: assert property (
    step_low && count_low_byte_q == 8'hff |=> low_overflow_flag_q)
    else $error("low byte wrap left low flag clear");

  flag_hold_a: assert property (
    high_overflow_flag_q && !wr_ctrl |=> high_overflow_flag_q)
    else $error("high flag cleared without a write");

  irq_follow_a: assert property (
    timer_irq_enable && high_overflow_flag_q |=> timer_irq_q)
    else $error("interrupt missing with high flag set");

  low_irq_a: assert property (
    timer_irq_q |-> $past(timer_irq_enable) &&
      ($past(high_overflow_flag_q) || ($past(low_overflow_flag_q) && $past(low_byte_irq_enable_q))))
    else $error("interrupt without an enabled cause");

  capture_copy_a: assert property (
    capture |=> reload_low_byte_q == $past(count_low_byte_q) &&
      reload_high_byte_q == $past(count_high_byte_q) && high_overflow_flag_q)
    else $error("capture did not copy the count");

  halt_hold_a: assert property (
    !split_mode_select_q && !run_control_bit_q && !wr_cnt_low && !wr_cnt_hi |=>
      $stable(count_low_byte_q) && $stable(count_high_byte_q))
    else $error("halted counter moved");

  split_low_a: assert property (
    split_mode_select_q && tick_low && count_low_byte_q != 8'hff && !wr_cnt_low |=>
      count_low_byte_q == $past(count_low_byte_q) + 8'h01)
    else $error("split low byte did not step");

  core_div_a: assert property (
    core_tick |=> !core_tick [*8] ##1 !core_tick [*3] ##1 core_tick)
    else $error("core divider is not twelve");

  reload_write_a: assert property (
    wr_rl_low && !capture |=> reload_low_byte_q == $past(sfr_wdata))
    else $error("reload low write lost");

endmodule

`default_nettype wire

// File: testbench/auto_reload_timer_control_tb.sv
// self-checking testbench for the auto-reload timer control block.
// assumes the design package is compiled first; the bench drives all ports
// itself at the falling edge of mclk and reads registers over the sfr port.
`timescale 1ns/1ps
`default_nettype none

module auto_reload_timer_control_tb;
  import reload_timer_pkg::*;

  // --------------------------------------------------------------------------
  // signals and counters
  // --------------------------------------------------------------------------
  logic       mclk;
  logic       reset_n;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic       sfr_wr_en;
  logic       sfr_rd_en;
  logic       timer_irq_enable;
  logic       high_byte_clock_select;
  logic       low_byte_clock_select;
  logic       ext_clock_pin;
  logic       low_freq_oscillator;
  logic [7:0] sfr_rdata_q;
  logic       timer_irq_q;
  logic       high_overflow_pulse_q;
  logic       low_overflow_pulse_q;
  logic [7:0] rd_val;
  int         mismatches;
  int         compares;
  int         hi_cnt;
  int         lo_cnt;

  auto_reload_timer_control i_auto_reload_timer_control (
    .mclk                   (mclk),
    .reset_n                (reset_n),
    .sfr_addr               (sfr_addr),
    .sfr_wdata              (sfr_wdata),
    .sfr_wr_en              (sfr_wr_en),
    .sfr_rd_en              (sfr_rd_en),
    .timer_irq_enable       (timer_irq_enable),
    .high_byte_clock_select (high_byte_clock_select),
    .low_byte_clock_select  (low_byte_clock_select),
    .ext_clock_pin          (ext_clock_pin),
    .low_freq_oscillator    (low_freq_oscillator),
    .sfr_rdata_q            (sfr_rdata_q),
    .timer_irq_q            (timer_irq_q),
    .high_overflow_pulse_q  (high_overflow_pulse_q),
    .low_overflow_pulse_q   (low_overflow_pulse_q)
  );

  // 50 MHz core clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // overflow pulses stand one cycle; tallied mid-cycle, away from the launching edge
  always @(negedge mclk) begin
    if (high_overflow_pulse_q === 1'b1) hi_cnt <= hi_cnt + 1;
    if (low_overflow_pulse_q === 1'b1) lo_cnt <= lo_cnt + 1;
  end

  // --------------------------------------------------------------------------
  // access and checking tasks
  // --------------------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr_en = 1'b1;
    @(negedge mclk);
    sfr_wr_en = 1'b0;
  endtask

  task automatic get(input logic [7:0] a);
    @(negedge mclk);
    sfr_addr  = a;
    sfr_rd_en = 1'b1;
    @(negedge mclk);
    sfr_rd_en = 1'b0;
    rd_val    = sfr_rdata_q;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    get(a);
    check($sformatf("register %h", a), rd_val, exp);
  endtask

  // per-byte selects act as exact tick sources: n cycles high give n steps
  task automatic tick(input int n, input logic hi);
    @(negedge mclk);
    low_byte_clock_select  = 1'b1;
    high_byte_clock_select = hi;
    repeat (n) @(negedge mclk);
    low_byte_clock_select  = 1'b0;
    high_byte_clock_select = 1'b0;
    repeat (3) @(negedge mclk);
  endtask

  // slow pin edges, well apart so the synchroniser never merges two of them
  task automatic pin_edges(input logic use_lfo, input int n);
    repeat (n) begin
      @(negedge mclk);
      if (use_lfo) low_freq_oscillator = 1'b1; else ext_clock_pin = 1'b1;
      repeat (2) @(negedge mclk);
      if (use_lfo) low_freq_oscillator = 1'b0; else ext_clock_pin = 1'b0;
      repeat (2) @(negedge mclk);
    end
  endtask

  task automatic irq_is(input logic exp);
    repeat (3) @(negedge mclk);
    check("interrupt request", {7'h00, timer_irq_q}, {7'h00, exp});
  endtask

  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // watchdog: the sequence needs about 650 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    end_sim();
  end

  // --------------------------------------------------------------------------
  // test sequence
  // --------------------------------------------------------------------------
  initial begin
    reset_n = 1'b0; sfr_addr = 8'h00; sfr_wdata = 8'h00; sfr_wr_en = 1'b0; sfr_rd_en = 1'b0;
    timer_irq_enable = 1'b0; high_byte_clock_select = 1'b0; low_byte_clock_select = 1'b0;
    ext_clock_pin = 1'b0; low_freq_oscillator = 1'b0; mismatches = 0; compares = 0;
    hi_cnt = 0; lo_cnt = 0;
    repeat (20) @(negedge mclk);
    reset_n = 1'b1;
    // reset values, unmapped address reads zero
    for (int a = 8'h90; a <= 8'h95; a++) rd(a[7:0], 8'h00);
    wr(ADDR_RELOAD_LOW, 8'h34);
    wr(ADDR_RELOAD_HIGH, 8'h12);
    wr(8'h96, 8'hff);
    rd(ADDR_RELOAD_LOW, 8'h34);
    rd(ADDR_RELOAD_HIGH, 8'h12);
    rd(8'h96, 8'h00);
    // 16-bit wrap from fffe with two ticks; alt 10 gives no ticks of its own
    wr(ADDR_CONTROL_STATUS, 8'h06);
    wr(ADDR_COUNT_LOW, 8'hfe);
    wr(ADDR_COUNT_HIGH, 8'hff);
    hi_cnt = 0; lo_cnt = 0;
    tick(2, 1'b0);
    check("high pulses", hi_cnt[7:0], 8'h01);
    check("low pulses", lo_cnt[7:0], 8'h01);
    rd(ADDR_COUNT_LOW, 8'h34);
    rd(ADDR_COUNT_HIGH, 8'h12);
    rd(ADDR_CONTROL_STATUS, 8'hc6);
    irq_is(1'b0);
    timer_irq_enable = 1'b1;
    irq_is(1'b1);
    repeat (20) @(negedge mclk);
    rd(ADDR_CONTROL_STATUS, 8'hc6);
    wr(ADDR_CONTROL_STATUS, 8'h06);
    irq_is(1'b0);
    // low wrap alone carries into the high byte and raises only the low flag
    wr(ADDR_COUNT_LOW, 8'hff);
    wr(ADDR_COUNT_HIGH, 8'h00);
    hi_cnt = 0; lo_cnt = 0;
    tick(1, 1'b0);
    check("high pulses", hi_cnt[7:0], 8'h00);
    check("low pulses", lo_cnt[7:0], 8'h01);
    rd(ADDR_COUNT_LOW, 8'h00);
    rd(ADDR_COUNT_HIGH, 8'h01);
    irq_is(1'b0);
    wr(ADDR_CONTROL_STATUS, 8'h66);
    irq_is(1'b1);
    // run bit low halts the 16-bit counter
    wr(ADDR_CONTROL_STATUS, 8'h02);
    tick(5, 1'b0);
    rd(ADDR_COUNT_LOW, 8'h00);
    rd(ADDR_COUNT_HIGH, 8'h01);
    // split mode: low byte runs without the run bit, each byte own reload
    wr(ADDR_CONTROL_STATUS, 8'h0a);
    wr(ADDR_COUNT_LOW, 8'hff);
    wr(ADDR_COUNT_HIGH, 8'hfe);
    hi_cnt = 0; lo_cnt = 0;
    tick(1, 1'b1);
    check("split pulses", {hi_cnt[3:0], lo_cnt[3:0]}, 8'h01);
    rd(ADDR_COUNT_LOW, 8'h34);
    rd(ADDR_COUNT_HIGH, 8'hfe);
    wr(ADDR_CONTROL_STATUS, 8'h0e);
    hi_cnt = 0; lo_cnt = 0;
    tick(2, 1'b1);
    check("split pulses", {hi_cnt[3:0], lo_cnt[3:0]}, 8'h10);
    rd(ADDR_COUNT_LOW, 8'h36);
    rd(ADDR_COUNT_HIGH, 8'h12);
    rd(ADDR_CONTROL_STATUS, 8'h8e);
    // core clock divided by twelve over about 122 cycles
    wr(ADDR_CONTROL_STATUS, 8'h00);
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_COUNT_HIGH, 8'h00);
    wr(ADDR_CONTROL_STATUS, 8'h04);
    repeat (120) @(negedge mclk);
    wr(ADDR_CONTROL_STATUS, 8'h00);
    get(ADDR_COUNT_LOW);
    check("core div12 steps", {7'h00, rd_val >= 8'h09 && rd_val <= 8'h0b}, 8'h01);
    // split mode: the shared core/12 source steps both bytes on the same ticks
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_COUNT_HIGH, 8'h00);
    wr(ADDR_CONTROL_STATUS, 8'h0c);
    repeat (120) @(negedge mclk);
    wr(ADDR_CONTROL_STATUS, 8'h00);
    get(ADDR_COUNT_HIGH);
    check("split core div12 steps", {7'h00, rd_val >= 8'h09 && rd_val <= 8'h0b}, 8'h01);
    rd(ADDR_COUNT_LOW, rd_val);
    // external pin and oscillator divided by eight: 16 edges give 2 steps
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_COUNT_LOW, 8'h00);
      wr(ADDR_CONTROL_STATUS, k == 0 ? 8'h05 : 8'h07);
      pin_edges(k == 1, 16);
      repeat (6) @(negedge mclk);
      wr(ADDR_CONTROL_STATUS, 8'h00);
      get(ADDR_COUNT_LOW);
      check("pin div8 steps", rd_val, 8'h02);
    end
    // capture on an oscillator falling edge with the counter held
    wr(ADDR_COUNT_LOW, 8'hcd);
    wr(ADDR_COUNT_HIGH, 8'hab);
    wr(ADDR_CONTROL_STATUS, 8'h10);
    irq_is(1'b0);
    @(negedge mclk);
    low_freq_oscillator = 1'b1;
    repeat (6) @(negedge mclk);
    low_freq_oscillator = 1'b0;
    repeat (6) @(negedge mclk);
    rd(ADDR_RELOAD_LOW, 8'hcd);
    rd(ADDR_RELOAD_HIGH, 8'hab);
    rd(ADDR_CONTROL_STATUS, 8'h90);
    irq_is(1'b1);
    end_sim();
  end

endmodule

`default_nettype wire
